// file: uart_reset_regs.sv
// Purpose: register bank of one uart channel with its reset defaults
// Assumes: rstn is the power-up reset; pins are asynchronous
// Notes: three reset sources; some registers load at power-up only
// Contract
// [R1] power-up loads divisor high 0x00 and divisor low 0x01
// [R2] any reset clears fraction, enables, controls, gpio, feature regs
// [R3] holding registers have no defined value after reset
// [R4] any reset sets interrupt source to 0x01, nothing pending
// [R5] any reset sets line control to 0x1d
// [R6] any reset sets line status to 0x60
// [R7] reset clears modem deltas; upper bits show inverted modem pins
// [R8] scratchpad loads 0xff at power-up only
// [R9] any reset sets halt/resume levels to 0x0f
// [R10] reset sets tx space count 0x40 and rx fill count 0x00
// [R11] four read/write flow-control character registers exist
// [R12] flow-control characters clear to 0x00 at power-up only
// [R13] reset pin leaves divisor, scratchpad, flow characters unchanged
// [R14] writing gpio control bit 3 starts a pin-like software reset
// [R15] tx, rts, dtr and irq outputs sit high during and after reset
// [R16] enhanced bits writable only while enhance bit set; clear latches
`include "uart_reset_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module uart_reset_regs
    import uart_reset_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic reset_pin_n,
    input wire logic [4:0] reg_idx,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [3:0] modem_in_n,
    input wire logic [7:0] gpio_in,
    output logic [7:0] gpio_out,
    output logic [7:0] gpio_oe,
    output logic tx,
    output logic rts_n,
    output logic dtr_n,
    output logic irq_n
);

    function automatic logic hit(input logic stb, input reg_idx_t a,
                                 input reg_idx_t i);
        return stb && (a == i);
    endfunction

    function automatic byte_t merge(input byte_t o, input byte_t n,
                                    input byte_t m);
        return (n & m) | (o & ~m);
    endfunction

    logic [12:0] pin_s1_r;
    logic [12:0] pin_s2_r;
    logic soft_rst_r;
    logic sys_rst;
    logic pin_rst;
    logic enh;
    byte_t ien_mask;
    byte_t fct_mask;
    byte_t mct_mask;
    byte_t enh_mask;

    byte_t divl_r;
    byte_t divh_r;
    byte_t scr_r;
    byte_t res1_r;
    byte_t res2_r;
    byte_t pau1_r;
    byte_t pau2_r;

    byte_t frac_r;
    byte_t ien_r;
    byte_t fct_r;
    byte_t lct_r;
    byte_t mct_r;
    byte_t lst_r;
    byte_t hrl_r;
    byte_t trl_r;
    byte_t txs_r;
    byte_t rxf_r;
    byte_t gdir_r;
    byte_t gst_r;
    byte_t gie_r;
    logic [2:0] gct_r;
    byte_t xfc_r;
    byte_t enf_r;

    logic [3:0] modem_prev_r;
    logic [3:0] delta_r;
    logic modem_irq;
    byte_t isrc;
    byte_t gst_view;
    byte_t rd_val;

    logic tx_r;
    logic rts_n_r;
    logic dtr_n_r;
    logic irq_n_r;
    byte_t rdata_r;

    logic we_divl;
    logic we_divh;
    logic we_scr;
    logic we_res1;
    logic we_res2;
    logic we_pau1;
    logic we_pau2;
    logic we_frac;
    logic we_ien;
    logic we_fct;
    logic we_lct;
    logic we_mct;
    logic we_hrl;
    logic we_trl;
    logic we_gdir;
    logic we_gst;
    logic we_gie;
    logic we_gct;
    logic we_xfc;
    logic we_enf;

    // two-stage synchronisers for every pin input
    // free running: a reset value would differ from the real pin
    // level and fake a modem edge right after reset
    always_ff @(posedge clk) begin
        pin_s1_r <= {reset_pin_n, gpio_in, modem_in_n};
        pin_s2_r <= pin_s1_r;
    end

    assign pin_rst = ~pin_s2_r[12];

    // self-clearing software reset pulse
    always_ff @(posedge clk) begin
        if (!rstn) begin
            soft_rst_r <= 1'b0;
        end else begin
            soft_rst_r <= hit(reg_wr, reg_idx, `RIDX_GCT) &&
                          reg_wdata[`GCT_SRST_BIT]; // [R14]
        end
    end

    assign sys_rst = !rstn || pin_rst || soft_rst_r; // [R14]

    assign enh = enf_r[`ENF_ENH_BIT];
    assign ien_mask = enh ? `MASK_ALL : `MASK_IEN_LEG; // [R16]
    assign fct_mask = enh ? `MASK_ALL : `MASK_FCT_LEG; // [R16]
    assign mct_mask = enh ? `MASK_ALL : `MASK_MCT_LEG; // [R16]
    assign enh_mask = enh ? `MASK_ALL : `MASK_NONE; // [R16]

    // per-register write enables
    assign we_divl = hit(reg_wr, reg_idx, `RIDX_DIVL);
    assign we_divh = hit(reg_wr, reg_idx, `RIDX_DIVH);
    assign we_scr = hit(reg_wr, reg_idx, `RIDX_SCR);
    assign we_res1 = hit(reg_wr, reg_idx, `RIDX_RES1);
    assign we_res2 = hit(reg_wr, reg_idx, `RIDX_RES2);
    assign we_pau1 = hit(reg_wr, reg_idx, `RIDX_PAU1);
    assign we_pau2 = hit(reg_wr, reg_idx, `RIDX_PAU2);
    assign we_frac = hit(reg_wr, reg_idx, `RIDX_FRAC);
    assign we_ien = hit(reg_wr, reg_idx, `RIDX_IEN);
    assign we_fct = hit(reg_wr, reg_idx, `RIDX_FCT);
    assign we_lct = hit(reg_wr, reg_idx, `RIDX_LCT);
    assign we_mct = hit(reg_wr, reg_idx, `RIDX_MCT);
    assign we_hrl = hit(reg_wr, reg_idx, `RIDX_HRL);
    assign we_trl = hit(reg_wr, reg_idx, `RIDX_TRL);
    assign we_gdir = hit(reg_wr, reg_idx, `RIDX_GDIR);
    assign we_gst = hit(reg_wr, reg_idx, `RIDX_GST);
    assign we_gie = hit(reg_wr, reg_idx, `RIDX_GIE);
    assign we_gct = hit(reg_wr, reg_idx, `RIDX_GCT);
    assign we_xfc = hit(reg_wr, reg_idx, `RIDX_XFC);
    assign we_enf = hit(reg_wr, reg_idx, `RIDX_ENF);

    // registers loaded at power-up only
    always_ff @(posedge clk) begin
        if (!rstn) begin // [R13]
            divh_r <= `RST_DIVH; // [R1]
            divl_r <= `RST_DIVL; // [R1]
            scr_r <= `RST_SCR; // [R8]
            res1_r <= `RST_FLOW; // [R12]
            res2_r <= `RST_FLOW; // [R12]
            pau1_r <= `RST_FLOW; // [R12]
            pau2_r <= `RST_FLOW; // [R12]
        end else begin
            if (we_divl) begin
                divl_r <= reg_wdata;
            end

            if (we_divh) begin
                divh_r <= reg_wdata;
            end

            if (we_scr) begin
                scr_r <= reg_wdata;
            end

            if (we_res1) begin
                res1_r <= reg_wdata; // [R11]
            end

            if (we_res2) begin
                res2_r <= reg_wdata; // [R11]
            end

            if (we_pau1) begin
                pau1_r <= reg_wdata; // [R11]
            end

            if (we_pau2) begin
                pau2_r <= reg_wdata; // [R11]
            end
        end
    end

    // registers set to their defaults by every reset source
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            frac_r <= `RST_ZERO; // [R2]
            ien_r <= `RST_ZERO; // [R2]
            fct_r <= `RST_ZERO; // [R2]
            lct_r <= `RST_LCT; // [R5]
            mct_r <= `RST_ZERO; // [R2]
            hrl_r <= `RST_HRL; // [R9]
            trl_r <= `RST_ZERO; // [R2]
            gdir_r <= `RST_ZERO; // [R2]
            gst_r <= `RST_ZERO; // [R2]
            gie_r <= `RST_ZERO; // [R2]
            gct_r <= 3'h0; // [R2]
            xfc_r <= `RST_ZERO; // [R2]
            enf_r <= `RST_ZERO; // [R2]
        end else begin
            // enhanced fields keep their value unless unlocked
            if (we_frac) begin
                frac_r <= merge(frac_r, reg_wdata, enh_mask); // [R16]
            end
            if (we_ien) begin
                ien_r <= merge(ien_r, reg_wdata, ien_mask); // [R16]
            end
            if (we_fct) begin
                fct_r <= merge(fct_r, reg_wdata, fct_mask); // [R16]
            end
            if (we_mct) begin
                mct_r <= merge(mct_r, reg_wdata, mct_mask); // [R16]
            end
            if (we_hrl) begin
                hrl_r <= merge(hrl_r, reg_wdata, enh_mask); // [R16]
            end
            if (we_trl) begin
                trl_r <= merge(trl_r, reg_wdata, enh_mask); // [R16]
            end

            // plain read/write registers
            if (we_lct) begin
                lct_r <= reg_wdata;
            end
            if (we_gdir) begin
                gdir_r <= reg_wdata;
            end
            if (we_gst) begin
                gst_r <= reg_wdata;
            end
            if (we_gie) begin
                gie_r <= reg_wdata;
            end
            if (we_gct) begin
                gct_r <= reg_wdata[2:0];
            end
            if (we_xfc) begin
                xfc_r <= reg_wdata;
            end
            if (we_enf) begin
                enf_r <= reg_wdata;
            end
        end
    end

    // status registers; no datapath moves them off their defaults
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lst_r <= `RST_LST; // [R6]
            txs_r <= `RST_TXS; // [R10]
            rxf_r <= `RST_RXF; // [R10]
        end else begin
            lst_r <= lst_r;
            txs_r <= txs_r;
            rxf_r <= rxf_r;
        end
    end

    // modem delta bits, cleared by reset and by a status read
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_modem
            always_ff @(posedge clk) begin
                modem_prev_r[gi] <= pin_s2_r[gi];
                if (sys_rst) begin
                    delta_r[gi] <= 1'b0; // [R7]
                end else if (pin_s2_r[gi] != modem_prev_r[gi]) begin
                    delta_r[gi] <= 1'b1;
                end else if (hit(reg_rd, reg_idx, `RIDX_MST)) begin
                    delta_r[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    assign modem_irq = ien_r[`IEN_MODEM_BIT] && (|delta_r);
    assign isrc = modem_irq ? `ISRC_MODEM : `RST_ISRC; // [R4]
    assign gst_view = (gdir_r & gst_r) | (~gdir_r & pin_s2_r[11:4]);

    always_comb begin
        rd_val = 8'h00;
        unique case (reg_idx)
            `RIDX_RXH: rd_val = 8'h00; // [R3]
            `RIDX_IEN: rd_val = ien_r;
            `RIDX_ISRC: rd_val = isrc; // [R4]
            `RIDX_LCT: rd_val = lct_r;
            `RIDX_MCT: rd_val = mct_r;
            `RIDX_LST: rd_val = lst_r;
            `RIDX_MST: rd_val = {~pin_s2_r[3:0], delta_r}; // [R7]
            `RIDX_SCR: rd_val = scr_r;
            `RIDX_HRL: rd_val = hrl_r;
            `RIDX_TRL: rd_val = trl_r;
            `RIDX_TXS: rd_val = txs_r;
            `RIDX_RXF: rd_val = rxf_r;
            `RIDX_GDIR: rd_val = gdir_r;
            `RIDX_GST: rd_val = gst_view;
            `RIDX_GIE: rd_val = gie_r;
            `RIDX_GCT: rd_val = {5'h00, gct_r};
            `RIDX_XFC: rd_val = xfc_r;
            `RIDX_ENF: rd_val = enf_r;
            `RIDX_DIVL: rd_val = divl_r;
            `RIDX_DIVH: rd_val = divh_r;
            `RIDX_FRAC: rd_val = frac_r;
            `RIDX_RES1: rd_val = res1_r;
            `RIDX_RES2: rd_val = res2_r;
            `RIDX_PAU1: rd_val = pau1_r;
            `RIDX_PAU2: rd_val = pau2_r;
            default: rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata_r <= 8'h00;
        end else if (reg_rd) begin
            rdata_r <= rd_val;
        end
    end

    // serial and modem outputs held high under any reset
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tx_r <= 1'b1; // [R15]
            rts_n_r <= 1'b1; // [R15]
            dtr_n_r <= 1'b1; // [R15]
            irq_n_r <= 1'b1; // [R15]
        end else begin
            tx_r <= ~lct_r[`LCT_BRK_BIT];
            rts_n_r <= ~mct_r[`MCT_RTS_BIT];
            dtr_n_r <= ~mct_r[`MCT_DTR_BIT];
            irq_n_r <= ~modem_irq;
        end
    end

    assign reg_rdata = rdata_r;
    assign gpio_out = gst_r;
    assign gpio_oe = gdir_r;
    assign tx = tx_r;
    assign rts_n = rts_n_r;
    assign dtr_n = dtr_n_r;
    assign irq_n = irq_n_r;

endmodule // uart_reset_regs

`default_nettype wire

// file: uart_reset_cfg.svh
// Purpose: offsets, reset values and bit positions of the uart channel
// Assumes: register index is 5 bits, one byte per register
// Notes: indices are flat, one per register
`ifndef UART_RESET_CFG_SVH
`define UART_RESET_CFG_SVH

`define RIDX_RXH 5'h00
`define RIDX_IEN 5'h01
`define RIDX_FCT 5'h02
`define RIDX_ISRC 5'h03
`define RIDX_LCT 5'h04
`define RIDX_MCT 5'h05
`define RIDX_LST 5'h06
`define RIDX_MST 5'h07
`define RIDX_SCR 5'h08
`define RIDX_HRL 5'h09
`define RIDX_TRL 5'h0a
`define RIDX_TXS 5'h0b
`define RIDX_RXF 5'h0c
`define RIDX_GDIR 5'h0d
`define RIDX_GST 5'h0e
`define RIDX_GIE 5'h0f
`define RIDX_GCT 5'h10
`define RIDX_XFC 5'h11
`define RIDX_ENF 5'h12
`define RIDX_DIVL 5'h13
`define RIDX_DIVH 5'h14
`define RIDX_FRAC 5'h15
`define RIDX_RES1 5'h16
`define RIDX_RES2 5'h17
`define RIDX_PAU1 5'h18
`define RIDX_PAU2 5'h19

`define RST_DIVH 8'h00
`define RST_DIVL 8'h01
`define RST_ZERO 8'h00
`define RST_ISRC 8'h01
`define RST_LCT 8'h1d
`define RST_LST 8'h60
`define RST_SCR 8'hff
`define RST_HRL 8'h0f
`define RST_TXS 8'h40
`define RST_RXF 8'h00
`define RST_FLOW 8'h00

`define ISRC_MODEM 8'h00
`define MASK_IEN_LEG 8'h0f
`define MASK_FCT_LEG 8'hcf
`define MASK_MCT_LEG 8'h1f
`define MASK_ALL 8'hff
`define MASK_NONE 8'h00

`define ENF_ENH_BIT 4
`define GCT_SRST_BIT 3
`define IEN_MODEM_BIT 3
`define MCT_DTR_BIT 0
`define MCT_RTS_BIT 1
`define LCT_BRK_BIT 6

`endif

// file: uart_reset_pkg.sv
// Purpose: shared types of the uart register bank
// Assumes: nothing
// Notes: constants live in uart_reset_cfg.svh
package uart_reset_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [4:0] reg_idx_t;
endpackage

// file: uart_reset_chk.sv
// Purpose: port checker for uart_reset_regs
// Assumes: rstn is the power-up reset, one clock
// Notes: bound into every uart_reset_regs instance
`include "uart_reset_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module uart_reset_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic reset_pin_n,
    input wire logic [4:0] reg_idx,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [3:0] modem_in_n,
    input wire logic [7:0] gpio_in,
    input wire logic [7:0] gpio_out,
    input wire logic [7:0] gpio_oe,
    input wire logic tx,
    input wire logic rts_n,
    input wire logic dtr_n,
    input wire logic irq_n
);
    logic [3:0] pin_hist_r;
    always_ff @(posedge clk) begin
        pin_hist_r <= rstn ? {pin_hist_r[2:0], reset_pin_n} : 4'h0;
    end
    // pin reset fully released for four edges
    wire logic ok = &pin_hist_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_idle;
        tx && rts_n && dtr_n && irq_n;
    endsequence
    sequence s_srst;
        ok && reg_wr && reg_idx == `RIDX_GCT && reg_wdata[`GCT_SRST_BIT];
    endsequence
    property p_por;
        $rose(rstn) |-> s_idle;
    endproperty
    a_por: assert property (p_por)
        else $error("outputs not idle after power-up");
    property p_srst;
        s_srst |=> ##1 s_idle;
    endproperty
    a_srst: assert property (p_srst)
        else $error("outputs not idle in software reset");
    property p_pin;
        $fell(reset_pin_n) ##1 !reset_pin_n [*2] |=> ##1 s_idle;
    endproperty
    a_pin: assert property (p_pin)
        else $error("outputs not idle in pin reset");
    property p_gpio;
        s_srst |=> ##2 gpio_oe == 8'h00 && gpio_out == 8'h00;
    endproperty
    a_gpio: assert property (p_gpio)
        else $error("gpio not cleared by software reset");
    property p_txs;
        ok && reg_rd && reg_idx == `RIDX_TXS |=> reg_rdata == `RST_TXS;
    endproperty
    a_txs: assert property (p_txs)
        else $error("tx space count wrong");
    property p_rxf;
        ok && reg_rd && reg_idx == `RIDX_RXF |=> reg_rdata == `RST_RXF;
    endproperty
    a_rxf: assert property (p_rxf)
        else $error("rx fill count wrong");
    property p_lst;
        ok && reg_rd && reg_idx == `RIDX_LST |=> reg_rdata == `RST_LST;
    endproperty
    a_lst: assert property (p_lst)
        else $error("line status wrong");
    property p_msr;
        ok && reg_rd && reg_idx == `RIDX_MST
            && modem_in_n == $past(modem_in_n, 4)
            |=> reg_rdata[7:4] == ~$past(modem_in_n);
    endproperty
    a_msr: assert property (p_msr)
        else $error("modem status upper bits wrong");
endmodule // uart_reset_chk
bind uart_reset_regs uart_reset_chk u_chk (.clk(clk), .rstn(rstn),
    .reset_pin_n(reset_pin_n), .reg_idx(reg_idx), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .modem_in_n(modem_in_n), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .tx(tx), .rts_n(rts_n), .dtr_n(dtr_n),
    .irq_n(irq_n));
`default_nettype wire

// file: uart_host_model.sv
// Purpose: host model driving the uart register port
// Assumes: tasks entered just after a rising edge
// Notes: write data inverted when idle
`timescale 1ns/10ps
`default_nettype none
module uart_host_model
    import uart_reset_pkg::*;
(
    input wire logic clk,
    output logic [4:0] reg_idx,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata
);
    initial begin
        reg_idx = 5'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    task automatic wr(input reg_idx_t i, input byte_t d);
        reg_idx <= i;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
        @(posedge clk);
    endtask
    task automatic rd(input reg_idx_t i);
        reg_idx <= i;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic srst();
        wr(5'h10, 8'h08);
    endtask
endmodule // uart_host_model
`default_nettype wire

// file: uart_register_reset_defaults_test.sv
// Purpose: self-checking bench of uart_reset_regs
// Assumes: 50 MHz clk, rstn low 12 cycles
// Notes: holding register never read, its value is undefined
`timescale 1ns/10ps
`default_nettype none
module uart_register_reset_defaults_test import uart_reset_pkg::*;;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic reset_pin_n = 1'b1;
    logic [3:0] modem_in_n = 4'h5;
    logic [7:0] gpio_in = 8'h00;
    logic [4:0] reg_idx;
    logic reg_wr, reg_rd, tx, rts_n, dtr_n, irq_n;
    logic [7:0] reg_wdata, reg_rdata, gpio_out, gpio_oe;
    logic rd_seen = 1'b0;
    byte_t lf = 8'h4a;
    byte_t po [32];
    byte_t exp_q [$];
    int n_mismatch = 0;
    int samples_checked = 0;
    initial begin
        forever #10 clk = ~clk;
    end
    uart_reset_regs u_dut (.clk(clk), .rstn(rstn),
        .reset_pin_n(reset_pin_n), .reg_idx(reg_idx), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .modem_in_n(modem_in_n), .gpio_in(gpio_in), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .tx(tx), .rts_n(rts_n), .dtr_n(dtr_n),
        .irq_n(irq_n));
    uart_host_model u_host (.clk(clk), .reg_idx(reg_idx),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
    function automatic byte_t nx(byte_t s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic byte_t dflt(reg_idx_t i);
        case (i)
            5'h03, 5'h13: return 8'h01;
            5'h04: return 8'h1d;
            5'h06: return 8'h60;
            5'h07: return {~modem_in_n, 4'h0};
            5'h08: return 8'hff;
            5'h09: return 8'h0f;
            5'h0b: return 8'h40;
            default: return 8'h00;
        endcase
    endfunction
    function automatic bit keeps(reg_idx_t i);
        return i inside {5'h08, 5'h13, 5'h14, [5'h16:5'h19]};
    endfunction
    task automatic chk(input byte_t s, input byte_t e);
        samples_checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %0t read %h expected %h", $time, s, e);
        end
    endtask
    task automatic rd(input reg_idx_t i, input byte_t e);
        exp_q.push_back(e);
        u_host.rd(i);
    endtask
    // index 0 skipped: holding registers undefined
    task automatic sweep(input bit kept);
        for (int i = 1; i < 26; i++) begin
            rd(5'(i), kept && keeps(5'(i)) ? po[i] : dflt(5'(i)));
        end
    endtask
    task automatic fill();
        for (int i = 1; i < 26; i++) begin
            lf = nx(lf);
            po[i] = lf;
            if (i != 16) u_host.wr(5'(i), lf);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        rd_seen <= reg_rd;
    end
    always @(negedge clk) begin
        if (rd_seen === 1'b1) begin
            chk(reg_rdata, exp_q.pop_front());
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        sweep(1'b0);
        $display("test power_up done");
        fill();
        reset_pin_n <= 1'b0;
        repeat (5) @(posedge clk);
        reset_pin_n <= 1'b1;
        repeat (5) @(posedge clk);
        sweep(1'b1);
        $display("test pin_reset done");
        fill();
        u_host.srst();
        repeat (3) @(posedge clk);
        sweep(1'b1);
        $display("test soft_reset done");
        u_host.wr(5'h09, 8'h33);
        rd(5'h09, 8'h0f);
        u_host.wr(5'h12, 8'h10);
        u_host.wr(5'h09, 8'h33);
        u_host.wr(5'h12, 8'h00);
        u_host.wr(5'h09, 8'h55);
        rd(5'h09, 8'h33);
        u_host.wr(5'h1f, 8'ha5);
        rd(5'h1f, 8'h00);
        $display("test enhanced_lock done");
        u_host.wr(5'h01, 8'h08);
        modem_in_n <= 4'h4;
        repeat (6) @(posedge clk);
        rd(5'h03, 8'h00);
        rd(5'h07, 8'hb1);
        rd(5'h07, 8'hb0);
        repeat (2) @(posedge clk);
        rd(5'h03, 8'h01);
        $display("test modem_delta done");
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        sweep(1'b0);
        $display("test second_power_up done");
        repeat (3) @(posedge clk);
        conclude();
    end
    // tests need about 370 cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        conclude();
    end
endmodule // uart_register_reset_defaults_test
`default_nettype wire
